// File: hdl/iocf_hyst.sv
// Direction dependent hysteresis of one axis
`timescale 1ns/1ps
module iocf_hyst
   import iocf_pkg::*;
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic signed [31:0] phys_in,
   input wire logic [15:0] hyst_in,
   output logic signed [31:0] pos_out
);
   logic signed [32:0] band;
   logic signed [32:0] diff;

   assign band = $signed({17'h0_0000, hyst_in});
   assign diff = 33'(phys_in) - 33'(pos_out);

   // ----------------------------------------
   // Tracking
   // ----------------------------------------
   // The reported value lags the physical one by the band, on the side it came from
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         pos_out <= 32'sh0000_0000;
      else if (diff > band)
         pos_out <= 32'(33'(phys_in) - band);
      else if (diff < -band)
         pos_out <= 32'(33'(phys_in) + band);
   end

   AST_HYST_BAND: assert property (@(posedge mclk_in) disable iff (srst_in)
      !$past(srst_in) |-> ((33'($past(phys_in)) - 33'(pos_out)) <= $past(band)) &&
         ((33'(pos_out) - 33'($past(phys_in))) <= $past(band)))
      else $error("Reported position outside hysteresis band");
endmodule : iocf_hyst

// File: hdl/iocf_output_config.sv
// Output configuration and diagnostics of a two-axis inclination readout
// Summary of operation
// - Angle mode change restores defaults of limits, resolution, presets and offsets.
// - Preset mode 0 keeps physical range and adds preset offset to output.
// - Preset mode 1 keeps position limits and moves the zero point.
// - Longitudinal output has 32-bit min and max limit, entry count two.
// - Lateral output has its own signed 32-bit min and max limit.
// - Limit values are in units of the current resolution.
// - Reported position trails physical position by hysteresis, per direction.
// - X, Y and Z acceleration readable as signed 16-bit milli-g.
// - Diagnostics word packs range, self-check and temperature status, resets zero.
// - Range and self-check fields: 0 normal, 1 below, 2 above.
// - Temperature field: 0 inside -40 to +85 C, 1 below, 2 above.
// - Resolution sets scaling of short and wide slope outputs.
// - Resolution codes 1, 10, 100, 1000; default 10.
// - Resolution change rescales stored presets and offsets.
`timescale 1ns/1ps
module iocf_output_config
   import iocf_pkg::*;
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic [15:0] obj_index_in,
   input wire logic [7:0] obj_sub_in,
   input wire logic obj_wr_in,
   input wire logic obj_rd_in,
   input wire logic [31:0] obj_wdata_in,
   output logic obj_ack_out,
   output logic obj_err_out,
   output logic [31:0] obj_rdata_out,
   input wire logic signed [31:0] phys_long_in,
   input wire logic signed [31:0] phys_lat_in,
   input wire logic signed [15:0] accel_x_in,
   input wire logic signed [15:0] accel_y_in,
   input wire logic signed [15:0] accel_z_in,
   input wire logic signed [15:0] self_check_in,
   input wire logic signed [15:0] temp_in,
   output logic defaults_restore_out,
   output logic signed [31:0] longitudinal_slope_wide_out,
   output logic signed [31:0] lateral_slope_wide_out,
   output logic signed [15:0] longitudinal_slope_short_out,
   output logic signed [15:0] lateral_slope_short_out,
   output logic [15:0] diag_out
);
   // ----------------------------------------
   // Arithmetic helpers
   // ----------------------------------------
   function automatic logic signed [47:0] div_res(input logic signed [47:0] v,
                                                  input logic [15:0] r);
      div_res = v / $signed({32'h0000_0000, r});
   endfunction : div_res

   // Rounding toward zero is accepted when stored values change resolution
   function automatic logic signed [31:0] rescale(input logic signed [31:0] v,
                                                  input logic [15:0] r_old,
                                                  input logic [15:0] r_new);
      logic signed [47:0] wide;
      wide = 48'(v) * $signed({32'h0000_0000, r_old});
      rescale = 32'(div_res(wide, r_new));
   endfunction : rescale

   function automatic logic [1:0] range_state(input logic signed [47:0] v,
                                              input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
      if (v < 48'(lo))
         range_state = ST_LOW;
      else if (v > 48'(hi))
         range_state = ST_HIGH;
      else
         range_state = ST_OK;
   endfunction : range_state

   function automatic logic signed [31:0] clamp(input logic signed [47:0] v,
                                                input logic signed [31:0] lo,
                                                input logic signed [31:0] hi);
      if (v < 48'(lo))
         clamp = lo;
      else if (v > 48'(hi))
         clamp = hi;
      else
         clamp = 32'(v);
   endfunction : clamp

   function automatic logic res_legal(input logic [15:0] r);
      res_legal = (r == RES_MILLI) || (r == RES_CENTI) || (r == RES_DECI) ||
         (r == RES_DEGREE);
   endfunction : res_legal

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0] angle_mode_reg;
   logic [7:0] preset_mode_reg;
   logic signed [31:0] long_min_reg;
   logic signed [31:0] long_max_reg;
   logic signed [31:0] lat_min_reg;
   logic signed [31:0] lat_max_reg;
   logic [15:0] hyst_reg;
   logic [15:0] res_reg;
   logic signed [31:0] long_preset_reg;
   logic signed [31:0] lat_preset_reg;
   logic signed [31:0] long_off_reg;
   logic signed [31:0] lat_off_reg;
   logic signed [15:0] accel_reg [3];
   logic signed [15:0] self_check_reg;
   logic [15:0] diag_reg;

   logic signed [31:0] long_pos;
   logic signed [31:0] lat_pos;
   logic signed [47:0] long_scaled;
   logic signed [47:0] lat_scaled;
   logic signed [47:0] long_sum;
   logic signed [47:0] lat_sum;
   logic signed [47:0] half_span;

   logic wr_ok;
   logic wr_err;
   logic mode_change;
   logic res_change;
   logic [15:0] new_res;

   iocf_hyst u_hyst_long (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .phys_in(phys_long_in),
      .hyst_in(hyst_reg),
      .pos_out(long_pos)
   );

   iocf_hyst u_hyst_lat (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .phys_in(phys_lat_in),
      .hyst_in(hyst_reg),
      .pos_out(lat_pos)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   always_comb
   begin
      wr_ok = 1'b0;
      new_res = obj_wdata_in[15:0];
      case (obj_index_in)
         OBJ_ANGLE_MODE:
            wr_ok = (obj_sub_in == SUB_COUNT) && (obj_wdata_in >= 32'(ANGLE_MODE_MIN)) &&
               (obj_wdata_in <= 32'(ANGLE_MODE_MAX));
         OBJ_PRESET_MODE:
            wr_ok = (obj_sub_in == SUB_COUNT) && (obj_wdata_in <= 32'(PRESET_MODE_SHIFT));
         OBJ_LONG_LIMIT, OBJ_LAT_LIMIT:
            wr_ok = (obj_sub_in == SUB_MIN) || (obj_sub_in == SUB_MAX);
         OBJ_HYSTERESIS:
            wr_ok = (obj_sub_in == SUB_COUNT) && (obj_wdata_in[31:16] == 16'h0000);
         OBJ_RESOLUTION:
            wr_ok = (obj_sub_in == SUB_COUNT) && (obj_wdata_in[31:16] == 16'h0000) &&
               res_legal(new_res);
         OBJ_LONG_PRESET, OBJ_LAT_PRESET:
            wr_ok = (obj_sub_in == SUB_COUNT);
         default:
            wr_ok = 1'b0;
      endcase
   end

   assign wr_err = obj_wr_in && !wr_ok;
   assign mode_change = obj_wr_in && wr_ok && (obj_index_in == OBJ_ANGLE_MODE) &&
      (obj_wdata_in[7:0] != angle_mode_reg);
   assign res_change = obj_wr_in && wr_ok && (obj_index_in == OBJ_RESOLUTION) &&
      (new_res != res_reg);

   // ----------------------------------------
   // Mode and setting registers
   // ----------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         angle_mode_reg <= ANGLE_MODE_DEF;
         preset_mode_reg <= PRESET_MODE_DEF;
         hyst_reg <= HYST_DEF;
      end
      else if (obj_wr_in && wr_ok)
      begin
         if (obj_index_in == OBJ_ANGLE_MODE)
            angle_mode_reg <= obj_wdata_in[7:0];
         if (obj_index_in == OBJ_PRESET_MODE)
            preset_mode_reg <= obj_wdata_in[7:0];
         if (obj_index_in == OBJ_HYSTERESIS)
            hyst_reg <= obj_wdata_in[15:0];
      end
   end

   // Other objects of the device restore on this pulse as well
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         defaults_restore_out <= 1'b0;
      else
         defaults_restore_out <= mode_change;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in || mode_change)
      begin
         long_min_reg <= LIMIT_MIN_DEF;
         long_max_reg <= LIMIT_MAX_DEF;
         lat_min_reg <= LIMIT_MIN_DEF;
         lat_max_reg <= LIMIT_MAX_DEF;
         res_reg <= RES_DEF;
      end
      else if (obj_wr_in && wr_ok)
      begin
         if (obj_index_in == OBJ_LONG_LIMIT && obj_sub_in == SUB_MIN)
            long_min_reg <= obj_wdata_in;
         if (obj_index_in == OBJ_LONG_LIMIT && obj_sub_in == SUB_MAX)
            long_max_reg <= obj_wdata_in;
         if (obj_index_in == OBJ_LAT_LIMIT && obj_sub_in == SUB_MIN)
            lat_min_reg <= obj_wdata_in;
         if (obj_index_in == OBJ_LAT_LIMIT && obj_sub_in == SUB_MAX)
            lat_max_reg <= obj_wdata_in;
         if (obj_index_in == OBJ_RESOLUTION)
            res_reg <= new_res;
      end
   end

   // ----------------------------------------
   // Presets and offsets
   // ----------------------------------------
   // Offset is taken against the position at the moment the preset is written
   always_ff @(posedge mclk_in)
   begin
      if (srst_in || mode_change)
      begin
         long_preset_reg <= 32'sh0000_0000;
         lat_preset_reg <= 32'sh0000_0000;
         long_off_reg <= 32'sh0000_0000;
         lat_off_reg <= 32'sh0000_0000;
      end
      else if (res_change)
      begin
         long_preset_reg <= rescale(long_preset_reg, res_reg, new_res);
         lat_preset_reg <= rescale(lat_preset_reg, res_reg, new_res);
         long_off_reg <= rescale(long_off_reg, res_reg, new_res);
         lat_off_reg <= rescale(lat_off_reg, res_reg, new_res);
      end
      else if (obj_wr_in && wr_ok && obj_index_in == OBJ_LONG_PRESET)
      begin
         long_preset_reg <= obj_wdata_in;
         long_off_reg <= 32'(48'($signed(obj_wdata_in)) - long_scaled);
      end
      else if (obj_wr_in && wr_ok && obj_index_in == OBJ_LAT_PRESET)
      begin
         lat_preset_reg <= obj_wdata_in;
         lat_off_reg <= 32'(48'($signed(obj_wdata_in)) - lat_scaled);
      end
   end

   // ----------------------------------------
   // Output path
   // ----------------------------------------
   assign long_scaled = div_res(48'(long_pos), res_reg);
   assign lat_scaled = div_res(48'(lat_pos), res_reg);
   assign half_span = div_res(HALF_TURN_MDEG, res_reg);

   // Mode 1 folds the shifted value back into the unchanged position range
   always_comb
   begin
      long_sum = long_scaled + 48'(long_off_reg);
      lat_sum = lat_scaled + 48'(lat_off_reg);
      if (preset_mode_reg == PRESET_MODE_SHIFT)
      begin
         if (long_sum >= half_span)
            long_sum = long_sum - (half_span <<< 1);
         else if (long_sum < -half_span)
            long_sum = long_sum + (half_span <<< 1);
         if (lat_sum >= half_span)
            lat_sum = lat_sum - (half_span <<< 1);
         else if (lat_sum < -half_span)
            lat_sum = lat_sum + (half_span <<< 1);
      end
   end

   // Limits are compared in resolution units, no conversion is applied
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         longitudinal_slope_wide_out <= 32'sh0000_0000;
         lateral_slope_wide_out <= 32'sh0000_0000;
         longitudinal_slope_short_out <= 16'sh0000;
         lateral_slope_short_out <= 16'sh0000;
      end
      else
      begin
         longitudinal_slope_wide_out <= clamp(long_sum, long_min_reg, long_max_reg);
         lateral_slope_wide_out <= clamp(lat_sum, lat_min_reg, lat_max_reg);
         longitudinal_slope_short_out <= 16'(clamp(long_sum, long_min_reg, long_max_reg));
         lateral_slope_short_out <= 16'(clamp(lat_sum, lat_min_reg, lat_max_reg));
      end
   end

   // ----------------------------------------
   // Sampled values and diagnostics
   // ----------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         accel_reg <= '{default: 16'sh0000};
         self_check_reg <= 16'sh0000;
      end
      else
      begin
         accel_reg <= '{accel_x_in, accel_y_in, accel_z_in};
         self_check_reg <= self_check_in;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         diag_reg <= DIAG_DEF;
      else
      begin
         diag_reg <= 16'h0000;
         diag_reg[DG_LONG_LSB +: 2] <= range_state(long_sum, long_min_reg, long_max_reg);
         diag_reg[DG_LAT_LSB +: 2] <= range_state(lat_sum, lat_min_reg, lat_max_reg);
         diag_reg[DG_SELF_LSB +: 2] <= range_state(48'(self_check_in),
            32'(SELF_CHECK_LOW), 32'(SELF_CHECK_HIGH));
         diag_reg[DG_TEMP_LSB +: 2] <= range_state(48'(temp_in),
            32'(TEMP_MIN_C), 32'(TEMP_MAX_C));
      end
   end

   assign diag_out = diag_reg;

   // ----------------------------------------
   // Object read and answer
   // ----------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         obj_ack_out <= 1'b0;
         obj_err_out <= 1'b0;
         obj_rdata_out <= 32'h0000_0000;
      end
      else
      begin
         obj_ack_out <= obj_wr_in || obj_rd_in;
         obj_err_out <= wr_err;
         if (obj_rd_in)
         begin
            obj_rdata_out <= 32'h0000_0000;
            case (obj_index_in)
               OBJ_ANGLE_MODE: obj_rdata_out <= 32'(angle_mode_reg);
               OBJ_PRESET_MODE: obj_rdata_out <= 32'(preset_mode_reg);
               OBJ_LONG_LIMIT:
                  obj_rdata_out <= (obj_sub_in == SUB_COUNT) ? 32'(LIMIT_COUNT) :
                     (obj_sub_in == SUB_MIN) ? long_min_reg : long_max_reg;
               OBJ_LAT_LIMIT:
                  obj_rdata_out <= (obj_sub_in == SUB_COUNT) ? 32'(LIMIT_COUNT) :
                     (obj_sub_in == SUB_MIN) ? lat_min_reg : lat_max_reg;
               OBJ_HYSTERESIS: obj_rdata_out <= 32'(hyst_reg);
               OBJ_ACCEL_X: obj_rdata_out <= 32'(accel_reg[0]);
               OBJ_ACCEL_Y: obj_rdata_out <= 32'(accel_reg[1]);
               OBJ_ACCEL_Z: obj_rdata_out <= 32'(accel_reg[2]);
               OBJ_DIAG: obj_rdata_out <= 32'(diag_reg);
               OBJ_SELF_CHECK: obj_rdata_out <= 32'(self_check_reg);
               OBJ_RESOLUTION: obj_rdata_out <= 32'(res_reg);
               OBJ_LONG_PRESET: obj_rdata_out <= long_preset_reg;
               OBJ_LAT_PRESET: obj_rdata_out <= lat_preset_reg;
               default: obj_rdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);

   sequence seq_mode_write;
      mode_change;
   endsequence

   sequence seq_defaults_seen;
      defaults_restore_out && res_reg == RES_DEF && long_min_reg == LIMIT_MIN_DEF &&
         lat_max_reg == LIMIT_MAX_DEF && long_off_reg == 32'sh0000_0000;
   endsequence

   AST_MODE_DEFAULTS: assert property (seq_mode_write |=> seq_defaults_seen)
      else $error("Angle mode change did not restore defaults");
   AST_RES_LEGAL: assert property (res_legal(res_reg))
      else $error("Resolution holds an illegal code");
   AST_PRESET_MODE_RANGE: assert property (preset_mode_reg <= PRESET_MODE_SHIFT)
      else $error("Preset mode out of range");
   AST_LONG_CLAMP: assert property (long_min_reg <= long_max_reg && $stable(long_min_reg)
      |=> longitudinal_slope_wide_out >= $past(long_min_reg) &&
         longitudinal_slope_wide_out <= $past(long_max_reg))
      else $error("Longitudinal output outside its limits");
   AST_LONG_LOW_STATUS: assert property (long_sum < 48'(long_min_reg)
      |=> diag_reg[DG_LONG_LSB +: 2] == ST_LOW &&
         longitudinal_slope_wide_out == $past(long_min_reg))
      else $error("Low clamp without low status");
   AST_LAT_INDEPENDENT: assert property (obj_wr_in && obj_index_in == OBJ_LONG_LIMIT &&
      !mode_change |=> $stable(lat_min_reg) && $stable(lat_max_reg))
      else $error("Longitudinal limit write changed lateral limits");
   AST_TEMP_HIGH: assert property (temp_in > TEMP_MAX_C
      |=> diag_reg[DG_TEMP_LSB +: 2] == ST_HIGH)
      else $error("Hot temperature not flagged");
   AST_DIAG_RESERVED: assert property (diag_reg[15:8] == 8'h00)
      else $error("Reserved diagnostics bits set");
   AST_ACCEL_READ: assert property (obj_rd_in && obj_index_in == OBJ_ACCEL_X
      |=> obj_ack_out && obj_rdata_out == 32'($past(accel_reg[0])))
      else $error("Acceleration read returned wrong value");
   AST_RES_RESCALE: assert property (res_change && !mode_change ##1 obj_ack_out
      |-> long_preset_reg == rescale($past(long_preset_reg), $past(res_reg), res_reg))
      else $error("Preset not rescaled on resolution change");
endmodule : iocf_output_config

// File: hdl/iocf_pkg.sv
// Package: object indices, field layout, reset values and limits of the output configuration
package iocf_pkg;
   // ----------------------------------------
   // Object indices and subindices
   // ----------------------------------------
   localparam logic [15:0] OBJ_ANGLE_MODE = 16'h3200;
   localparam logic [15:0] OBJ_PRESET_MODE = 16'h3250;
   localparam logic [15:0] OBJ_LONG_LIMIT = 16'h3300;
   localparam logic [15:0] OBJ_LAT_LIMIT = 16'h3301;
   localparam logic [15:0] OBJ_HYSTERESIS = 16'h3310;
   localparam logic [15:0] OBJ_ACCEL_X = 16'h3403;
   localparam logic [15:0] OBJ_ACCEL_Y = 16'h3404;
   localparam logic [15:0] OBJ_ACCEL_Z = 16'h3405;
   localparam logic [15:0] OBJ_DIAG = 16'h3450;
   localparam logic [15:0] OBJ_SELF_CHECK = 16'h3451;
   localparam logic [15:0] OBJ_RESOLUTION = 16'h6000;
   localparam logic [15:0] OBJ_LONG_PRESET = 16'h6112;
   localparam logic [15:0] OBJ_LAT_PRESET = 16'h6122;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_MIN = 8'h01;
   localparam logic [7:0] SUB_MAX = 8'h02;
   // ----------------------------------------
   // Reset values and legal codes
   // ----------------------------------------
   localparam logic [7:0] ANGLE_MODE_DEF = 8'h01;
   localparam logic [7:0] ANGLE_MODE_MIN = 8'h01;
   localparam logic [7:0] ANGLE_MODE_MAX = 8'h04;
   localparam logic [7:0] PRESET_MODE_DEF = 8'h00;
   localparam logic [7:0] PRESET_MODE_SHIFT = 8'h01;
   localparam logic [7:0] LIMIT_COUNT = 8'h02;
   localparam logic signed [31:0] LIMIT_MIN_DEF = 32'sh8000_0000;
   localparam logic signed [31:0] LIMIT_MAX_DEF = 32'sh7fff_ffff;
   localparam logic [15:0] HYST_DEF = 16'h0000;
   localparam logic [15:0] RES_MILLI = 16'h0001;
   localparam logic [15:0] RES_CENTI = 16'h000a;
   localparam logic [15:0] RES_DECI = 16'h0064;
   localparam logic [15:0] RES_DEGREE = 16'h03e8;
   localparam logic [15:0] RES_DEF = RES_CENTI;
   // Half turn in 0.001 degree, used for the wrap of the shifted-zero preset mode
   localparam logic signed [47:0] HALF_TURN_MDEG = 48'sh0000_0002_bf20;
   // ----------------------------------------
   // Diagnostics word layout and status codes
   // ----------------------------------------
   localparam int DG_LONG_LSB = 0;
   localparam int DG_LAT_LSB = 2;
   localparam int DG_SELF_LSB = 4;
   localparam int DG_TEMP_LSB = 6;
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_LOW = 2'h1;
   localparam logic [1:0] ST_HIGH = 2'h2;
   localparam logic [15:0] DIAG_DEF = 16'h0000;
   localparam logic signed [15:0] TEMP_MIN_C = 16'shffd8;
   localparam logic signed [15:0] TEMP_MAX_C = 16'sh0055;
   localparam logic signed [15:0] SELF_CHECK_LOW = 16'shf000;
   localparam logic signed [15:0] SELF_CHECK_HIGH = 16'sh1000;
endpackage : iocf_pkg

// File: tb/iocf_master_model.sv
// Network master stand-in that reads and writes objects one at a time
`timescale 1ns/1ps
module iocf_master_model
   import iocf_pkg::*;
(
   input wire logic mclk_in,
   input wire logic obj_ack_in,
   input wire logic obj_err_in,
   input wire logic [31:0] obj_rdata_in,
   output logic [15:0] obj_index_out,
   output logic [7:0] obj_sub_out,
   output logic obj_wr_out,
   output logic obj_rd_out,
   output logic [31:0] obj_wdata_out
);
   initial
   begin
      obj_index_out = 16'h0000;
      obj_sub_out = 8'h00;
      obj_wr_out = 1'b0;
      obj_rd_out = 1'b0;
      obj_wdata_out = 32'h0000_0000;
   end
   // Request is a one-cycle pulse, so the answer is taken in the next cycle only
   task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, output logic a, output logic e, output logic [31:0] q);
      @(posedge mclk_in);
      #1;
      obj_index_out = i;
      obj_sub_out = s;
      obj_wdata_out = d;
      obj_wr_out = w;
      obj_rd_out = !w;
      @(posedge mclk_in);
      #1;
      obj_wr_out = 1'b0;
      obj_rd_out = 1'b0;
      // Released data must not keep looking valid
      obj_wdata_out = ~d;
      a = obj_ack_in;
      e = obj_err_in;
      q = obj_rdata_in;
   endtask : access
endmodule : iocf_master_model

// File: tb/iocf_output_config_test.sv
// Self-checking bench of the output configuration block
`timescale 1ns/1ps
module iocf_output_config_test
   import iocf_pkg::*;
;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [15:0] idx;
   logic [7:0] sub;
   logic wr_s, rd_s, ack, err, dro;
   logic [31:0] wd, rq, lw, tw;
   logic signed [31:0] pl = 0, pt = 0;
   logic signed [15:0] temp = 16'sh0019, self = 16'sh0000, ls, ts;
   logic [15:0] diag;
   int mismatches = 0;
   int checked = 0;
   logic [31:0] res_codes [4] = '{32'(RES_MILLI), 32'(RES_CENTI), 32'(RES_DECI), 32'(RES_DEGREE)};
   always #10 mclk_in = ~mclk_in;
   iocf_master_model mm (.mclk_in(mclk_in), .obj_ack_in(ack), .obj_err_in(err),
      .obj_rdata_in(rq), .obj_index_out(idx), .obj_sub_out(sub), .obj_wr_out(wr_s),
      .obj_rd_out(rd_s), .obj_wdata_out(wd));
   iocf_output_config dut (.mclk_in(mclk_in), .srst_in(srst_in), .obj_index_in(idx),
      .obj_sub_in(sub), .obj_wr_in(wr_s), .obj_rd_in(rd_s), .obj_wdata_in(wd),
      .obj_ack_out(ack), .obj_err_out(err), .obj_rdata_out(rq), .phys_long_in(pl),
      .phys_lat_in(pt), .accel_x_in(16'sh0123), .accel_y_in(16'shfffb),
      .accel_z_in(16'sh03e8), .self_check_in(self), .temp_in(temp),
      .defaults_restore_out(dro), .longitudinal_slope_wide_out(lw),
      .lateral_slope_wide_out(tw), .longitudinal_slope_short_out(ls),
      .lateral_slope_short_out(ts), .diag_out(diag));
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
      input logic e);
      logic a, r;
      logic [31:0] q;
      mm.access(1'b1, i, s, d, a, r, q);
      chk("ack", 32'(a), 32'h0000_0001);
      chk("err", 32'(r), 32'(e));
   endtask : wr
   task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
      logic a, r;
      logic [31:0] q;
      mm.access(1'b0, i, s, 32'h0000_0000, a, r, q);
      chk("rack", 32'(a), 32'h0000_0001);
      chk("rdata", q, x);
   endtask : rd
   // Slope path and range status need two cycles, temperature and self-check one; four leaves margin
   task automatic drive(input logic signed [31:0] l, input logic signed [31:0] t,
      input logic signed [15:0] c, input logic signed [15:0] f);
      @(posedge mclk_in);
      #1;
      pl = l;
      pt = t;
      temp = c;
      self = f;
      repeat (4) @(posedge mclk_in);
      #1;
   endtask : drive
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial
   begin
      #100000;
      mismatches++;
      end_sim();
   end
   initial
   begin
      repeat (4) @(posedge mclk_in);
      #1;
      srst_in = 1'b0;
      rd(OBJ_RESOLUTION, SUB_COUNT, 32'h0000_000a);
      rd(OBJ_HYSTERESIS, SUB_COUNT, 32'h0000_0000);
      rd(OBJ_LONG_LIMIT, SUB_COUNT, 32'h0000_0002);
      rd(OBJ_LAT_LIMIT, SUB_MAX, 32'h7fff_ffff);
      rd(OBJ_DIAG, SUB_COUNT, 32'h0000_0000);
      rd(OBJ_ACCEL_X, SUB_COUNT, 32'h0000_0123);
      rd(OBJ_ACCEL_Y, SUB_COUNT, 32'hffff_fffb);
      rd(OBJ_ACCEL_Z, SUB_COUNT, 32'h0000_03e8);
      wr(OBJ_ACCEL_X, SUB_COUNT, 32'h0000_0001, 1'b1);
      wr(OBJ_LAT_LIMIT, SUB_COUNT, 32'h0000_0005, 1'b1);
      wr(OBJ_PRESET_MODE, SUB_COUNT, 32'h0000_0002, 1'b1);
      wr(OBJ_PRESET_MODE, SUB_COUNT, 32'h0000_0001, 1'b0);
      rd(OBJ_PRESET_MODE, SUB_COUNT, 32'h0000_0001);
      wr(OBJ_PRESET_MODE, SUB_COUNT, 32'h0000_0000, 1'b0);
      wr(OBJ_HYSTERESIS, SUB_COUNT, 32'h0001_0000, 1'b1);
      foreach (res_codes[k])
      begin
         wr(OBJ_RESOLUTION, SUB_COUNT, res_codes[k], 1'b0);
         rd(OBJ_RESOLUTION, SUB_COUNT, res_codes[k]);
      end
      wr(OBJ_RESOLUTION, SUB_COUNT, 32'h0000_0003, 1'b1);
      drive(32'sh0000_1388, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0000_0005);
      wr(OBJ_RESOLUTION, SUB_COUNT, 32'(RES_MILLI), 1'b0);
      drive(32'sh0001_e240, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0001_e240);
      chk("long_short", 32'(ls), 32'hffff_e240);
      wr(OBJ_RESOLUTION, SUB_COUNT, 32'(RES_CENTI), 1'b0);
      wr(OBJ_LONG_LIMIT, SUB_MIN, 32'hffff_ff9c, 1'b0);
      wr(OBJ_LONG_LIMIT, SUB_MAX, 32'h0000_0064, 1'b0);
      wr(OBJ_LAT_LIMIT, SUB_MIN, 32'hffff_ffce, 1'b0);
      wr(OBJ_LAT_LIMIT, SUB_MAX, 32'h0000_0032, 1'b0);
      drive(32'sh0000_1388, 32'shffff_fce0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0000_0064);
      chk("lat_wide", tw, 32'hffff_ffce);
      chk("lat_short", 32'(ts), 32'hffff_ffce);
      chk("diag", 32'(diag), 32'h0000_0006);
      drive(32'shffff_ec78, 32'sh0000_012c, 16'shffd7, 16'sh1001);
      chk("lat_wide", tw, 32'h0000_001e);
      chk("diag", 32'(diag), 32'h0000_0061);
      drive(32'sh0000_0000, 0, 16'sh0056, 16'shefff);
      rd(OBJ_DIAG, SUB_COUNT, 32'h0000_0090);
      rd(OBJ_SELF_CHECK, SUB_COUNT, 32'hffff_efff);
      drive(0, 0, 16'shffd8, 16'sh0000);
      chk("diag", 32'(diag), 32'h0000_0000);
      drive(0, 0, 16'sh0055, 16'sh0000);
      chk("diag", 32'(diag), 32'h0000_0000);
      wr(OBJ_ANGLE_MODE, SUB_COUNT, 32'h0000_0002, 1'b0);
      chk("restore", 32'(dro), 32'h0000_0001);
      rd(OBJ_LONG_LIMIT, SUB_MIN, 32'h8000_0000);
      // Store-all lives outside this block, so it answers as an unknown object
      wr(16'h1010, 8'h01, 32'h6576_6173, 1'b1);
      rd(OBJ_ANGLE_MODE, SUB_COUNT, 32'h0000_0002);
      wr(OBJ_ANGLE_MODE, SUB_COUNT, 32'h0000_0002, 1'b0);
      chk("restore", 32'(dro), 32'h0000_0000);
      wr(OBJ_ANGLE_MODE, SUB_COUNT, 32'h0000_0005, 1'b1);
      wr(OBJ_LONG_PRESET, SUB_COUNT, 32'h0000_0064, 1'b0);
      drive(0, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0000_0064);
      wr(OBJ_RESOLUTION, SUB_COUNT, 32'(RES_DECI), 1'b0);
      rd(OBJ_LONG_PRESET, SUB_COUNT, 32'h0000_000a);
      wr(OBJ_HYSTERESIS, SUB_COUNT, 32'h0000_07d0, 1'b0);
      drive(32'sh0000_1388, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0000_0028);
      drive(32'sh0000_0fa0, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0000_0028);
      drive(0, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'h0000_001e);
      wr(OBJ_PRESET_MODE, SUB_COUNT, 32'h0000_0001, 1'b0);
      wr(OBJ_LONG_PRESET, SUB_COUNT, 32'h0000_0708, 1'b0);
      drive(0, 0, 16'sh0019, 16'sh0000);
      chk("long_wide", lw, 32'hffff_f8f8);
      end_sim();
   end
endmodule : iocf_output_config_test
